// ---- ccd_defines.svh ----
// Purpose: Offsets, field positions, reset values and counts of the
//          clock source and divider block.
// Assumes: Word-aligned registers on a 32-bit bus.
// Notes:   Definitions only.
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

`define CCD_ADR_CTRL   6'h00
`define CCD_ADR_BUS    6'h01
`define CCD_ADR_CPU    6'h02
`define CCD_ADR_STAT   6'h03
`define CCD_ADR_DIG0   6'h04
`define CCD_ADR_ANA0   6'h0c
`define CCD_ADR_END    6'h10

`define CCD_CTRL_RST   32'h0000_0003
`define CCD_CTRL_MASK  32'h0000_03ff
`define CCD_DIV_RST    32'h0000_0002
`define CCD_ANA_MASK   32'h0037_ffff
`define CCD_DIG_MASK   32'h0007_ffff
`define CCD_BUS_MASK   32'h0000_ffff
`define CCD_CPU_MASK   32'h0000_000f

`define CCD_CTRL_REGD  0
`define CCD_CTRL_REGA  1
`define CCD_CTRL_WLP   2
`define CCD_CTRL_UDBL  3
`define CCD_CTRL_USEL  4
`define CCD_CTRL_MSEL  6
`define CCD_CTRL_XEN   9

`define CCD_RTC_TICKS  32768
`define CCD_DIV_MIN    2

`endif

// ---- ccd_pkg.sv ----
// Purpose: Types shared by the clock source and divider block.
// Assumes: Nothing beyond the defines header.
// Notes:   Divider configuration travels as one packed word.
package ccd_pkg;

    typedef struct packed {
        logic [1:0]  skew;
        logic [2:0]  src;
        logic [15:0] div;
    } ccd_div_cfg_t;

    typedef enum logic [2:0] {
        CCD_SRC_IMO   = 3'b000,
        CCD_SRC_XTAL  = 3'b001,
        CCD_SRC_FAB   = 3'b010,
        CCD_SRC_PLL   = 3'b011,
        CCD_SRC_DBL   = 3'b100,
        CCD_SRC_LSO   = 3'b101,
        CCD_SRC_WATCH = 3'b110,
        CCD_SRC_OWN   = 3'b111
    } ccd_src_t;

    typedef enum logic {
        CCD_WB_IDLE = 1'b0,
        CCD_WB_ACK  = 1'b1
    } ccd_wb_st_t;

endpackage

// ---- ccd_divider.sv ----
// Purpose: One clock divider: source mux, counter, resync and skew.
// Assumes: Source ticks are one-cycle pulses on the master clock.
// Notes:   New settings load only while the counter rests at zero.
`timescale 1ns/1ps
`include "ccd_defines.svh"

module ccd_divider #(
    parameter int WIDTH  = 16,
    parameter int SKEW_W = 2
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Sources and settings
    input  wire logic [7:0]           src_tick,
    input  ccd_pkg::ccd_div_cfg_t     cfg,
    // Divided clock
    output logic                      clk_o,
    output logic                      en_o
);
    import ccd_pkg::*;

    localparam int DEPTH = (1 << SKEW_W) - 1;

    ccd_div_cfg_t     live_r;
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic [WIDTH-1:0] eff_m1;
    logic [DEPTH-1:0] sk_r;
    logic             out_r;
    logic             src_hit;
    logic             tap;

    // Ratios below two are clamped so no half phase can vanish
    assign eff_m1  = (live_r.div[WIDTH-1:0] < WIDTH'(`CCD_DIV_MIN)) ?
                     WIDTH'(`CCD_DIV_MIN - 1) :
                     live_r.div[WIDTH-1:0] - WIDTH'(1);
    assign src_hit = src_tick[live_r.src];
    assign cnt_nxt = (cnt_r == eff_m1) ? '0 : cnt_r + WIDTH'(1);
    assign tap     = (live_r.skew == '0) ? out_r :
                     sk_r[live_r.skew - SKEW_W'(1)];

    // Zero is the start of the low phase, so a ratio or source change never cuts a pulse
    always_ff @(posedge clk or posedge rst)
        if (rst)
            live_r <= ccd_div_cfg_t'(`CCD_DIV_RST);
        else if (cnt_r == '0)
            live_r <= cfg;

    always_ff @(posedge clk or posedge rst)
        if (rst)
            cnt_r <= '0;
        else if (src_hit)
            cnt_r <= cnt_nxt;

    // Low for the first half, high for the rest: about half duty
    always_ff @(posedge clk or posedge rst)
        if (rst)
            out_r <= 1'b0;
        else if (src_hit)
            out_r <= (cnt_nxt > (eff_m1 >> 1));

    // Registered on the master clock; the skew taps shift every master cycle
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            sk_r  <= '0;
            clk_o <= 1'b0;
            en_o  <= 1'b0;
        end
        else
        begin
            sk_r  <= {sk_r[DEPTH-2:0], out_r};
            clk_o <= tap;
            en_o  <= tap & ~clk_o;
        end

    chk_out_on_tick: assert property (@(posedge clk) disable iff (rst)
        $changed(out_r) |-> $past(src_hit))
        else $error("divider output moved without a source tick");

    chk_cfg_boundary: assert property (@(posedge clk) disable iff (rst)
        $changed(live_r) |-> ($past(cnt_r) == '0))
        else $error("divider settings changed mid cycle");

    chk_half_wrap: assert property (@(posedge clk) disable iff (rst)
        (src_hit && cnt_r == eff_m1) |=> (cnt_r == '0 && !out_r))
        else $error("divider cycle did not end low at zero");

    chk_cnt_bound: assert property (@(posedge clk) disable iff (rst)
        cnt_r <= eff_m1)
        else $error("divider count beyond its ratio");

    chk_skew_zero: assert property (@(posedge clk) disable iff (rst)
        (live_r.skew == '0) |=> (clk_o == $past(out_r)))
        else $error("unskewed output not one cycle behind");

endmodule

// ---- ccd_rtc.sv ----
// Purpose: One-second event and seconds count from the watch crystal.
// Assumes: tick is one pulse per watch crystal period.
// Notes:   Firmware keeps calendar time on top of sec_o.
`timescale 1ns/1ps

module ccd_rtc #(
    parameter int TICKS = 32768
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Watch crystal tick
    input  wire logic        tick,
    // Second event and count
    output logic             sec_o,
    output logic [15:0]      secs_o
);
    localparam int CW = $clog2(TICKS);
    localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

    logic [CW-1:0] cnt_r;

    always_ff @(posedge clk or posedge rst)
        if (rst)
            cnt_r <= '0;
        else if (tick)
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            sec_o  <= 1'b0;
            secs_o <= '0;
        end
        else
        begin
            sec_o <= tick && (cnt_r == LAST);
            if (tick && cnt_r == LAST)
                secs_o <= secs_o + 16'h0001;
        end

    chk_rtc_second: assert property (@(posedge clk) disable iff (rst)
        (tick && cnt_r == LAST) |=> (sec_o && cnt_r == '0))
        else $error("second event missing at watch wrap");

endmodule

// ---- ccd_top.sv ----
// Purpose: Clock source routing and divider tree with register access.
// Assumes: CLK_SYS is the master clock; source inputs are synchronous
//          levels; classic Wishbone slave with 32-bit data.
// Notes:   Divided clocks leave as levels plus one-cycle enables.
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "ccd_defines.svh"

module ccd_top #(
    parameter int RTC_TICKS = `CCD_RTC_TICKS
) (
    // Master clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              SYS_RST,
    // Wishbone slave
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [7:0]        WB_ADR_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic [31:0]            WB_DAT_O,
    output logic                   WB_ACK_O,
    // Clock sources
    input  wire logic              INT_MAIN_OSC,
    input  wire logic              FAST_CRYSTAL_OSC,
    input  wire logic              FABRIC_CLK,
    input  wire logic              PLL_CLK,
    input  wire logic              LOW_SPEED_OSC,
    input  wire logic              WATCH_CRYSTAL_OSC,
    input  wire logic [7:0]        FABRIC_DIV_CLK,
    input  wire logic              USB_FABRIC_CLK,
    // Divided clocks and the USB clock enable
    output logic [7:0]             DIG_CLK,
    output logic [7:0]             DIG_CLK_EN,
    output logic [3:0]             ANA_CLK,
    output logic [3:0]             ANA_CLK_EN,
    output logic                   BUS_CLK,
    output logic                   BUS_CLK_EN,
    output logic                   CPU_CLK,
    output logic                   CPU_CLK_EN,
    output logic                   USB_CLK_EN,
    // Timer clocks and events
    output logic                   SLEEP_TIMER_CLK,
    output logic                   RTC_SEC,
    // Oscillator and supply control
    output logic                   WATCH_LOW_POWER,
    output logic                   FAST_XTAL_EN,
    output logic [2:0]             MCLK_SEL,
    output logic                   REG_DIG_EN,
    output logic                   REG_ANA_EN
);
    import ccd_pkg::*;

    ccd_wb_st_t    st_r;
    ccd_wb_st_t    st_nxt;
    logic [5:0]    widx;
    logic [2:0]    dsel;
    logic          wr_go;
    logic [31:0]   rd_nxt;
    logic [31:0]   ctrl_r;
    logic [31:0]   bus_r;
    logic [31:0]   cpu_r;
    logic [31:0]   dig_r [8];
    logic [31:0]   ana_r [4];
    logic [15:0]   rtc_secs;
    logic [6:0]    src_lvl;
    logic [6:0]    src_prev_r;
    logic [6:0]    src_tick;
    logic          dbl_lvl;
    logic          dbl_prev_r;
    logic          dbl_tick;
    logic          usbf_prev_r;
    logic [7:0]    fab_prev_r;
    logic [7:0]    fab_tick;
    logic          rtc_pulse;

    // Byte-lane merge, then clear bits that do not exist
    function automatic logic [31:0] wr_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel,
        input logic [31:0] msk
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[8*b +: 8] = wd[8*b +: 8];
        return r & msk;
    endfunction

    assign widx  = WB_ADR_I[7:2];
    assign dsel  = 3'(widx - `CCD_ADR_DIG0);
    assign wr_go = WB_CYC_I & WB_STB_I & WB_WE_I & (st_r == CCD_WB_ACK);

    // Bus handshake: answer one cycle after the request, for one cycle
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            CCD_WB_IDLE:
                if (WB_CYC_I && WB_STB_I)
                    st_nxt = CCD_WB_ACK;
            CCD_WB_ACK:
                st_nxt = CCD_WB_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
            st_r <= CCD_WB_IDLE;
        else
            st_r <= st_nxt;

    assign WB_ACK_O = (st_r == CCD_WB_ACK);

    // Unmapped words read zero and swallow writes
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (widx == `CCD_ADR_CTRL)
            rd_nxt = ctrl_r;
        else if (widx == `CCD_ADR_BUS)
            rd_nxt = bus_r;
        else if (widx == `CCD_ADR_CPU)
            rd_nxt = cpu_r;
        else if (widx == `CCD_ADR_STAT)
            rd_nxt = {rtc_secs, 2'b00, CPU_CLK, BUS_CLK, ANA_CLK, DIG_CLK};
        else if (widx >= `CCD_ADR_DIG0 && widx < `CCD_ADR_ANA0)
            rd_nxt = dig_r[dsel];
        else if (widx >= `CCD_ADR_ANA0 && widx < `CCD_ADR_END)
            rd_nxt = ana_r[widx[1:0]];
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
            WB_DAT_O <= 32'h0000_0000;
        else if (st_r == CCD_WB_IDLE && WB_CYC_I && WB_STB_I)
            WB_DAT_O <= rd_nxt;

    // Control word; regulators default on after reset
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
            ctrl_r <= `CCD_CTRL_RST;
        else if (wr_go && widx == `CCD_ADR_CTRL)
            ctrl_r <= wr_merge(ctrl_r, WB_DAT_I, WB_SEL_I, `CCD_CTRL_MASK);

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
        begin
            bus_r <= `CCD_DIV_RST;
            cpu_r <= `CCD_DIV_RST;
        end
        else if (wr_go && widx == `CCD_ADR_BUS)
            bus_r <= wr_merge(bus_r, WB_DAT_I, WB_SEL_I, `CCD_BUS_MASK);
        else if (wr_go && widx == `CCD_ADR_CPU)
            cpu_r <= wr_merge(cpu_r, WB_DAT_I, WB_SEL_I, `CCD_CPU_MASK);

    // Digital dividers carry no skew field, so it always reads zero
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
        begin
            for (int i = 0; i < 8; i++)
                dig_r[i] <= `CCD_DIV_RST;
            for (int i = 0; i < 4; i++)
                ana_r[i] <= `CCD_DIV_RST;
        end
        else if (wr_go && widx >= `CCD_ADR_DIG0 && widx < `CCD_ADR_ANA0)
            dig_r[dsel] <= wr_merge(dig_r[dsel], WB_DAT_I, WB_SEL_I,
                                    `CCD_DIG_MASK);
        else if (wr_go && widx >= `CCD_ADR_ANA0 && widx < `CCD_ADR_END)
            ana_r[widx[1:0]] <= wr_merge(ana_r[widx[1:0]], WB_DAT_I,
                                         WB_SEL_I, `CCD_ANA_MASK);

    assign REG_DIG_EN      = ctrl_r[`CCD_CTRL_REGD];
    assign REG_ANA_EN      = ctrl_r[`CCD_CTRL_REGA];
    assign WATCH_LOW_POWER = ctrl_r[`CCD_CTRL_WLP];
    assign FAST_XTAL_EN    = ctrl_r[`CCD_CTRL_XEN];
    // The chip's master mux picks the source set in the control word; this block runs on it
    assign MCLK_SEL        = ctrl_r[`CCD_CTRL_MSEL +: 3];

    // The seven general sources, in mux order
    assign src_lvl[CCD_SRC_IMO]   = INT_MAIN_OSC;
    assign src_lvl[CCD_SRC_XTAL]  = FAST_CRYSTAL_OSC;
    assign src_lvl[CCD_SRC_FAB]   = FABRIC_CLK;
    assign src_lvl[CCD_SRC_PLL]   = PLL_CLK;
    assign src_lvl[CCD_SRC_DBL]   = USB_CLK_EN;
    assign src_lvl[CCD_SRC_LSO]   = LOW_SPEED_OSC;
    assign src_lvl[CCD_SRC_WATCH] = WATCH_CRYSTAL_OSC;

    // Rising edges seen on the master clock become one-cycle ticks
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
        begin
            src_prev_r  <= '0;
            fab_prev_r  <= '0;
            usbf_prev_r <= 1'b0;
            dbl_prev_r  <= 1'b0;
        end
        else
        begin
            src_prev_r  <= src_lvl;
            fab_prev_r  <= FABRIC_DIV_CLK;
            usbf_prev_r <= USB_FABRIC_CLK;
            dbl_prev_r  <= dbl_lvl;
        end

    assign src_tick = src_lvl & ~src_prev_r;
    assign fab_tick = FABRIC_DIV_CLK & ~fab_prev_r;

    // The doubler counts both edges of the chosen 24 MHz source
    always_comb
    begin
        unique case (ctrl_r[`CCD_CTRL_USEL +: 2])
            2'h0:    dbl_lvl = INT_MAIN_OSC;
            2'h1:    dbl_lvl = FAST_CRYSTAL_OSC;
            2'h2:    dbl_lvl = FABRIC_CLK;
            default: dbl_lvl = 1'b0;
        endcase
    end

    assign dbl_tick = dbl_lvl ^ dbl_prev_r;

    // Only the enable leaves here; the USB data path has its own clock
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
            USB_CLK_EN <= 1'b0;
        else if (ctrl_r[`CCD_CTRL_UDBL])
            USB_CLK_EN <= dbl_tick;
        else
            USB_CLK_EN <= USB_FABRIC_CLK & ~usbf_prev_r;

    // Direct route, so duty follows the crystal, not a divider
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
        if (SYS_RST)
            SLEEP_TIMER_CLK <= 1'b0;
        else
            SLEEP_TIMER_CLK <= WATCH_CRYSTAL_OSC;

    ccd_rtc #(
        .TICKS (RTC_TICKS)
    ) u_rtc (
        .clk    (CLK_SYS),
        .rst    (SYS_RST),
        .tick   (src_tick[CCD_SRC_WATCH]),
        .sec_o  (rtc_pulse),
        .secs_o (rtc_secs)
    );

    assign RTC_SEC = rtc_pulse;

    // Digital dividers: own fabric clock in slot seven
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_dig
            ccd_divider #(
                .WIDTH  (16),
                .SKEW_W (2)
            ) u_div (
                .clk      (CLK_SYS),
                .rst      (SYS_RST),
                .src_tick ({fab_tick[gi], src_tick}),
                .cfg      (ccd_div_cfg_t'(dig_r[gi][20:0])),
                .clk_o    (DIG_CLK[gi]),
                .en_o     (DIG_CLK_EN[gi])
            );
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_ana
            ccd_divider #(
                .WIDTH  (16),
                .SKEW_W (2)
            ) u_div (
                .clk      (CLK_SYS),
                .rst      (SYS_RST),
                .src_tick ({1'b0, src_tick}),
                .cfg      (ccd_div_cfg_t'({ana_r[gi][21:20],
                                           ana_r[gi][18:0]})),
                .clk_o    (ANA_CLK[gi]),
                .en_o     (ANA_CLK_EN[gi])
            );
        end
    endgenerate

    // Bus divider counts every master clock cycle
    ccd_divider #(
        .WIDTH  (16),
        .SKEW_W (2)
    ) u_bus (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .src_tick (8'hff),
        .cfg      (ccd_div_cfg_t'(bus_r[20:0])),
        .clk_o    (BUS_CLK),
        .en_o     (BUS_CLK_EN)
    );

    ccd_divider #(
        .WIDTH  (4),
        .SKEW_W (2)
    ) u_cpu (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .src_tick ({8{BUS_CLK_EN}}),
        .cfg      (ccd_div_cfg_t'(cpu_r[20:0])),
        .clk_o    (CPU_CLK),
        .en_o     (CPU_CLK_EN)
    );

    chk_wb_answer: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus answer not one cycle after request");

    chk_cpu_from_bus: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(CPU_CLK) |-> $past(BUS_CLK_EN, 2))
        else $error("cpu clock rose without a bus clock tick");

    chk_usb_double: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ctrl_r[`CCD_CTRL_UDBL] && dbl_tick) |=> USB_CLK_EN)
        else $error("doubled usb tick missing");

endmodule

// ---- ccd_sink_model.sv ----
// Purpose: Clock consumer that times the high and low phases it sees.
// Assumes: Level input is sampled on the master clock.
// Notes:   Lengths are in master cycles and hold the last full phase.
`timescale 1ns/1ps

module ccd_sink_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Observed clock level
    input  wire logic       lvl,
    // Last complete phase lengths
    output logic [7:0]      hi_len,
    output logic [7:0]      lo_len
);
    logic [7:0] run_r;
    logic       prev_r;

    // A runt shows up as a phase of one cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run_r  <= 8'h01;
            prev_r <= 1'b0;
            hi_len <= 8'h00;
            lo_len <= 8'h00;
        end
        else if (lvl != prev_r)
        begin
            if (prev_r)
                hi_len <= run_r;
            else
                lo_len <= run_r;
            run_r  <= 8'h01;
            prev_r <= lvl;
        end
        else
            run_r <= run_r + 8'h01;
    end
endmodule

// ---- test_clock_source_distribution.sv ----
// Purpose: Self-checking bench for the clock source and divider block.
// Assumes: Sources toggle on master edges; RTC shortened to four ticks.
// Notes:   Pulse counts allow one edge of slack at window borders.
`timescale 1ns/1ps

module test_clock_source_distribution;
    logic        CLK_SYS = 1'b0, SYS_RST = 1'b1;
    logic        WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [3:0]  WB_SEL_I = 4'h0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
    logic        WB_ACK_O, BUS_CLK, BUS_CLK_EN, CPU_CLK, CPU_CLK_EN;
    logic        USB_CLK_EN, SLEEP_TIMER_CLK, RTC_SEC, WATCH_LOW_POWER;
    logic        FAST_XTAL_EN, REG_DIG_EN, REG_ANA_EN, wprev = 1'b0;
    logic [7:0]  DIG_CLK, DIG_CLK_EN, src = 8'h00, run = 8'h00;
    logic [3:0]  ANA_CLK, ANA_CLK_EN;
    logic [2:0]  MCLK_SEL;
    logic [7:0]  hi0, lo0, hib, lob, hic, loc;
    int          miscompares = 0, cmp_count = 0;
    wire         INT_MAIN_OSC = src[0], FAST_CRYSTAL_OSC = src[1];
    wire         FABRIC_CLK = src[2], PLL_CLK = src[3];
    wire         USB_FABRIC_CLK = src[4], LOW_SPEED_OSC = src[5];
    wire         WATCH_CRYSTAL_OSC = src[6];
    wire [7:0]   FABRIC_DIV_CLK = {8{src[7]}};
    wire [4:0]   mon = {CPU_CLK_EN, BUS_CLK_EN, RTC_SEC, USB_CLK_EN,
                        DIG_CLK_EN[1]};

    ccd_top #(.RTC_TICKS(4)) u_ccd_top (.*);
    ccd_sink_model u_ccd_sink_model_dig (.clk(CLK_SYS), .rst(SYS_RST),
        .lvl(DIG_CLK[0]), .hi_len(hi0), .lo_len(lo0));
    ccd_sink_model u_ccd_sink_model_bus (.clk(CLK_SYS), .rst(SYS_RST),
        .lvl(BUS_CLK), .hi_len(hib), .lo_len(lob));
    ccd_sink_model u_ccd_sink_model_cpu (.clk(CLK_SYS), .rst(SYS_RST),
        .lvl(CPU_CLK), .hi_len(hic), .lo_len(loc));

    always #20 CLK_SYS = ~CLK_SYS;
    // Each running source toggles every cycle: one tick per two cycles
    always @(posedge CLK_SYS) src <= src ^ run;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge CLK_SYS)
    begin
        if (!SYS_RST) check(SLEEP_TIMER_CLK, wprev);
        wprev <= WATCH_CRYSTAL_OSC;
    end

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= a;
        WB_SEL_I <= 4'hf;
        WB_DAT_I <= d;
        do @(posedge CLK_SYS); while (WB_ACK_O !== 1'b1 && ++n < 20);
        check(WB_ACK_O, 1'h1);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    function automatic logic near(input int n, input int e);
        return (e == 0) ? n == 0 : (n >= e - 1 && n <= e + 1);
    endfunction

    task automatic cnt(input int idx, input int cyc, output int n);
        n = 0;
        repeat (cyc)
        begin
            @(posedge CLK_SYS);
            n += (mon[idx] === 1'b1);
        end
    endtask

    task automatic wait_en;
        int n;
        n = 0;
        do @(posedge CLK_SYS); while (DIG_CLK_EN[0] !== 1'b1 && ++n < 50);
    endtask

    task automatic t_regs;
        rd(8'h00, 32'h3);
        check({REG_ANA_EN, REG_DIG_EN}, 2'h3);
        rd(8'h04, 32'h2);
        rd(8'h08, 32'h2);
        rd(8'h10, 32'h2);
        rd(8'h30, 32'h2);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        wr(8'h00, 32'h384);
        rd(8'h00, 32'h384);
        check({FAST_XTAL_EN, MCLK_SEL, WATCH_LOW_POWER, REG_ANA_EN,
               REG_DIG_EN}, 7'h74);
        wr(8'h00, 32'h3);
    endtask

    task automatic t_rtc;
        int a, b;
        logic [31:0] q;
        run <= 8'h40;
        cnt(2, 16, a);
        run <= 8'h00;
        cnt(2, 8, b);
        check(a + b, 32'h2);
        wb(1'b0, 8'h0c, 32'h0, q);
        check(q[31:16], 16'h2);
    endtask

    task automatic t_skew;
        logic [2:0] s;
        run <= 8'hff;
        wait_en;
        check(ANA_CLK_EN[0], 1'h1);
        wr(8'h30, 32'h0030_0002);
        repeat (8) @(posedge CLK_SYS);
        wait_en;
        for (int i = 2; i >= 0; i--)
        begin
            @(posedge CLK_SYS);
            s[i] = ANA_CLK_EN[0];
        end
        check(s, 3'h1);
        check(ANA_CLK[0], 1'h1);
    endtask

    task automatic t_div;
        logic [15:0] dv [4] = '{16'h0, 16'h2, 16'h4, 16'h5};
        logic [15:0] ex [4] = '{16'h0202, 16'h0202, 16'h0404, 16'h0406};
        foreach (dv[i])
        begin
            wr(8'h10, {16'h0, dv[i]});
            repeat (40) @(posedge CLK_SYS);
            check({hi0, lo0}, ex[i]);
        end
    endtask

    task automatic t_mux;
        int n;
        for (int s = 0; s < 8; s++)
        begin
            run <= 8'hff;
            wr(8'h14, {13'h0, s[2:0], 16'h2});
            repeat (8) @(posedge CLK_SYS);
            run <= 8'h01 << s;
            cnt(0, 40, n);
            check(near(n, 10), 1'h1);
            run <= ~(8'h01 << s);
            cnt(0, 4, n);
            cnt(0, 40, n);
            check(near(n, 0), 1'h1);
        end
    endtask

    task automatic t_bus;
        int n;
        wr(8'h04, 32'h4);
        wr(8'h08, 32'h3);
        repeat (60) @(posedge CLK_SYS);
        check({hib, lob, hic, loc}, 32'h0202_0408);
        cnt(3, 48, n);
        check(near(n, 12), 1'h1);
        cnt(4, 48, n);
        check(near(n, 4), 1'h1);
    endtask

    task automatic t_usb;
        int n;
        run <= 8'hff;
        for (int d = 0; d < 4; d++)
        begin
            wr(8'h00, 32'hb | (d << 4));
            cnt(1, 4, n);
            cnt(1, 40, n);
            check(near(n, d < 3 ? 40 : 0), 1'h1);
        end
        wr(8'h00, 32'h3);
        cnt(1, 4, n);
        cnt(1, 40, n);
        check(near(n, 20), 1'h1);
    endtask

    task automatic close_out;
        $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        t_regs;
        t_rtc;
        t_skew;
        t_div;
        t_mux;
        t_bus;
        t_usb;
        close_out;
    end

    // Whole run needs under two thousand cycles
    initial
    begin
        #(40 * 20000);
        miscompares++;
        close_out;
    end
endmodule
